// File: include/pwr_mode_pkg.sv
//------------------------------------------------------------
// Power mode controller constants
//------------------------------------------------------------
// Function
// - Four modes, decreasing consumption order
// - Active enables subsystems per template bit
// - Alternate active uses own template
// - Active: all peripherals available
// - Sleep disables most resources regardless
// - Sleep buzzes digital and analog regulators
// - Hibernate retains state, stops all clocks
// - Hibernate wakes only from port interrupts
// - Hibernate keeps only hibernate regulator
// - Regulators disableable when supplied externally
// - Regulators enabled after power-up
// - Wakeup returns to active, enables CPU
// - Sleep resume within 15 us
// - Hibernate resume below 100 us
package pwr_mode_pkg;

  // Register byte offsets
  localparam logic [7:0] MODE_OFS    = 8'h00;
  localparam logic [7:0] ACT_TPL_OFS = 8'h04;
  localparam logic [7:0] ALT_TPL_OFS = 8'h08;
  localparam logic [7:0] REG_CTL_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS  = 8'h10;
  localparam logic [7:0] WAKE_EN_OFS = 8'h14;

  // Reset values
  localparam logic [15:0] ACT_TPL_RST = 16'hffff;
  localparam logic [15:0] ALT_TPL_RST = 16'hfffe;
  localparam logic [1:0]  REG_CTL_RST = 2'h3;
  localparam logic [5:0]  WAKE_EN_RST = 6'h3f;

  // Subsystem bits; bit 0 is the CPU
  localparam int TPL_W     = 16;
  localparam int CPU_BIT   = 0;
  localparam logic [15:0] SLEEP_KEEP = 16'h0000;

  // Wake source positions
  localparam int WK_CMP  = 0;
  localparam int WK_PORT = 1;
  localparam int WK_I2C  = 2;
  localparam int WK_RTC  = 3;
  localparam int WK_TW   = 4;
  localparam int WK_LVD  = 5;

  // Timing
  localparam int CLK_MHZ        = 20;
  localparam int ENTRY_CYC      = 4;
  localparam int SLEEP_WAKE_US  = 15;
  localparam int HIB_WAKE_US    = 100;
  // Wake sample and mode update take the other cycles
  localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_US * CLK_MHZ - 2;
  localparam int HIB_WAKE_CYC   = HIB_WAKE_US * CLK_MHZ - 3;
  localparam int HIB_RESUME_MAX = HIB_WAKE_US * CLK_MHZ - 2;
  localparam int CNT_W          = 12;

  // Global modes in decreasing consumption
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_ALT    = 2'b01,
    MODE_SLEEP  = 2'b10,
    MODE_HIB    = 2'b11
  } gmode_t;

  // Controller states
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_ENTER  = 3'b001,
    ST_LOW    = 3'b010,
    ST_RESUME = 3'b011
  } pstate_t;

  // Regulator outputs
  typedef struct packed {
    logic dig_en;
    logic ana_en;
    logic dig_buzz;
    logic ana_buzz;
    logic sleep_en;
    logic hib_en;
  } reg_ctl_t;

  // Wake sources
  typedef struct packed {
    logic low_voltage_detect;
    logic timewheel;
    logic rtc;
    logic i2c;
    logic port_int;
    logic comparator;
  } wake_t;

endpackage

// File: core/power_mode_controller.sv
`timescale 1ns/1ps
module power_mode_controller (
  // Clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  NRST_I,
  // AHB-Lite slave
  input  wire logic                  HSEL_I,
  input  wire logic [7:0]            HADDR_I,
  input  wire logic [1:0]            HTRANS_I,
  input  wire logic                  HWRITE_I,
  input  wire logic [2:0]            HSIZE_I,
  input  wire logic [31:0]           HWDATA_I,
  input  wire logic                  HREADY_I,
  output logic      [31:0]           HRDATA_O,
  output logic                       HREADYOUT_O,
  output logic                       HRESP_O,
  // Wake sources
  input  wire pwr_mode_pkg::wake_t   WAKE_I,
  // Subsystem and power controls
  output logic      [15:0]           SUBSYS_EN_O,
  output logic                       CLK_RUN_O,
  output pwr_mode_pkg::reg_ctl_t     REGS_O,
  output pwr_mode_pkg::gmode_t       MODE_O
);
  import pwr_mode_pkg::*;

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  gmode_t          mode_r, target_r;
  pstate_t         st_r, st_nxt;
  logic [TPL_W-1:0] act_tpl_r, alt_tpl_r;
  logic [1:0]      reg_ctl_r;
  logic [5:0]      wake_en_r;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic            cpu_force_r;
  logic [7:0]      addr_r;
  logic            wr_r, rd_r;
  logic [31:0]     rdata_r;

  //------------------------------------------------------------
  // Bus decode
  //------------------------------------------------------------
  wire        ap_valid = HSEL_I && HREADY_I && HTRANS_I[1];
  wire        wr_mode  = wr_r && (addr_r == MODE_OFS);
  wire [1:0]  wr_val   = HWDATA_I[1:0];
  wire        req_low  = wr_mode && (wr_val != 2'b00);
  wire        req_act  = wr_mode && (wr_val == 2'b00);

  // Wake qualification per mode
  wire [5:0]  wake_vec = WAKE_I;
  wire [5:0]  sleep_mask = wake_en_r;
  wire [5:0]  hib_mask   = wake_en_r & (6'h01 << WK_PORT);
  wire        wake_q   = (target_r == MODE_HIB) ? |(wake_vec & hib_mask)
                                                : |(wake_vec & sleep_mask);
  wire        low_tgt  = (target_r == MODE_SLEEP) || (target_r == MODE_HIB);

  //------------------------------------------------------------
  // Sequencer next state
  //------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      ST_RUN: begin
        if (req_low) begin
          st_nxt  = ST_ENTER;
          cnt_nxt = CNT_W'(ENTRY_CYC);
        end
      end
      ST_ENTER: begin
        if (low_tgt && wake_q) begin
          st_nxt = ST_RUN;
        end else if (cnt_r == '0) begin
          st_nxt = low_tgt ? ST_LOW : ST_RUN;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_LOW: begin
        if (wake_q) begin
          st_nxt  = ST_RESUME;
          cnt_nxt = (target_r == MODE_HIB) ? CNT_W'(HIB_WAKE_CYC)
                                           : CNT_W'(SLEEP_WAKE_CYC);
        end
      end
      ST_RESUME: begin
        if (cnt_r == '0) begin
          st_nxt = ST_RUN;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  //------------------------------------------------------------
  // Bus phase registers
  //------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      addr_r <= 8'h00;
      wr_r   <= 1'b0;
      rd_r   <= 1'b0;
    end else begin
      addr_r <= HADDR_I;
      wr_r   <= ap_valid && HWRITE_I;
      rd_r   <= ap_valid && !HWRITE_I;
    end
  end

  //------------------------------------------------------------
  // Configuration registers
  //------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      act_tpl_r <= ACT_TPL_RST;
      alt_tpl_r <= ALT_TPL_RST;
      reg_ctl_r <= REG_CTL_RST;
      wake_en_r <= WAKE_EN_RST;
    end else if (wr_r) begin
      if (addr_r == ACT_TPL_OFS) act_tpl_r <= HWDATA_I[15:0];
      if (addr_r == ALT_TPL_OFS) alt_tpl_r <= HWDATA_I[15:0];
      if (addr_r == REG_CTL_OFS) reg_ctl_r <= HWDATA_I[1:0];
      if (addr_r == WAKE_EN_OFS) wake_en_r <= HWDATA_I[5:0];
    end
  end

  //------------------------------------------------------------
  // Mode and sequencer registers
  //------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      st_r        <= ST_RUN;
      cnt_r       <= '0;
      mode_r      <= MODE_ACTIVE;
      target_r    <= MODE_ACTIVE;
      cpu_force_r <= 1'b1;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      if (st_r == ST_RUN && req_low) begin
        target_r    <= gmode_t'(wr_val);
        cpu_force_r <= 1'b0;
      end else if (st_r == ST_RUN && req_act) begin
        mode_r   <= MODE_ACTIVE;
        target_r <= MODE_ACTIVE;
      end
      if (st_r == ST_ENTER && st_nxt == ST_LOW) begin
        mode_r <= target_r;
      end else if (st_r == ST_ENTER && st_nxt == ST_RUN) begin
        mode_r <= (low_tgt && wake_q) ? MODE_ACTIVE : target_r;
        if (low_tgt && wake_q) begin
          target_r    <= MODE_ACTIVE;
          cpu_force_r <= 1'b1;
        end
      end
      if (st_r == ST_RESUME && st_nxt == ST_RUN) begin
        mode_r      <= MODE_ACTIVE;
        target_r    <= MODE_ACTIVE;
        cpu_force_r <= 1'b1;
      end
    end
  end

  //------------------------------------------------------------
  // Read data
  //------------------------------------------------------------
  always_comb begin
    rdata_r = 32'h0000_0000;
    unique case (addr_r)
      MODE_OFS:    rdata_r = {30'h0, mode_r};
      ACT_TPL_OFS: rdata_r = {16'h0, act_tpl_r};
      ALT_TPL_OFS: rdata_r = {16'h0, alt_tpl_r};
      REG_CTL_OFS: rdata_r = {30'h0, reg_ctl_r};
      STATUS_OFS:  rdata_r = {27'h0, st_r, target_r};
      WAKE_EN_OFS: rdata_r = {26'h0, wake_en_r};
      default:     rdata_r = 32'h0000_0000;
    endcase
  end

  assign HRDATA_O    = rd_r ? rdata_r : 32'h0000_0000;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  //------------------------------------------------------------
  // Power outputs
  //------------------------------------------------------------
  wire in_low   = (st_r == ST_LOW) || (st_r == ST_RESUME);
  wire is_sleep = in_low && (mode_r == MODE_SLEEP);
  wire is_hib   = in_low && (mode_r == MODE_HIB);
  wire [TPL_W-1:0] run_tpl = (mode_r == MODE_ALT) ? alt_tpl_r : act_tpl_r;
  wire [TPL_W-1:0] cpu_bit = (cpu_force_r ? 16'h0001 : 16'h0000) << CPU_BIT;

  assign SUBSYS_EN_O = is_hib   ? 16'h0000 :
                       is_sleep ? SLEEP_KEEP :
                       (run_tpl | cpu_bit);
  assign CLK_RUN_O   = !is_hib;
  assign REGS_O = '{dig_en:   reg_ctl_r[0] && !is_hib,
                    ana_en:   reg_ctl_r[1] && !is_hib,
                    dig_buzz: is_sleep && reg_ctl_r[0],
                    ana_buzz: is_sleep && reg_ctl_r[1],
                    sleep_en: !is_hib,
                    hib_en:   1'b1};
  assign MODE_O          = mode_r;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  property p_reset_active;
    @(posedge CLK_I) !NRST_I |=> (MODE_O == MODE_ACTIVE) && REGS_O.dig_en && REGS_O.ana_en;
  endproperty
  a_reset_active: assert property (p_reset_active) else $error("Not active after reset");

  property p_hib_off;
    @(posedge CLK_I) disable iff (!NRST_I) is_hib |-> (SUBSYS_EN_O == 16'h0000) && !CLK_RUN_O && REGS_O.hib_en;
  endproperty
  a_hib_off: assert property (p_hib_off) else $error("Hibernate left something on");

  property p_sleep_buzz;
    @(posedge CLK_I) disable iff (!NRST_I) (is_sleep && reg_ctl_r == 2'h3) |-> REGS_O.dig_buzz && REGS_O.ana_buzz;
  endproperty
  a_sleep_buzz: assert property (p_sleep_buzz) else $error("Sleep regulators not buzzed");

  property p_hib_ignore;
    @(posedge CLK_I) disable iff (!NRST_I) (st_r == ST_LOW && mode_r == MODE_HIB && !WAKE_I.port_int) |=> st_r == ST_LOW;
  endproperty
  a_hib_ignore: assert property (p_hib_ignore) else $error("Hibernate woke without port interrupt");

  property p_sleep_wake;
    @(posedge CLK_I) disable iff (!NRST_I)
      (st_r == ST_LOW && mode_r == MODE_SLEEP && wake_q) |-> ##[1:301] (MODE_O == MODE_ACTIVE);
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("Sleep resume too slow");

  // Cycles spent resuming from hibernate
  logic [CNT_W-1:0] hib_wait_r;
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      hib_wait_r <= '0;
    end else if (is_hib && st_r == ST_RESUME) begin
      hib_wait_r <= hib_wait_r + 1'b1;
    end else begin
      hib_wait_r <= '0;
    end
  end

  property p_hib_wake;
    @(posedge CLK_I) disable iff (!NRST_I)
      (is_hib && st_r == ST_RESUME) |-> (hib_wait_r < CNT_W'(HIB_RESUME_MAX));
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("Hibernate resume too slow");

  property p_sleep_off;
    @(posedge CLK_I) disable iff (!NRST_I) is_sleep |-> (SUBSYS_EN_O == SLEEP_KEEP);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("Sleep left subsystems on");

  property p_act_tpl;
    @(posedge CLK_I) disable iff (!NRST_I)
      (!in_low && mode_r == MODE_ACTIVE && !cpu_force_r) |-> (SUBSYS_EN_O == act_tpl_r);
  endproperty
  a_act_tpl: assert property (p_act_tpl) else $error("Active template not applied");

  property p_alt_tpl;
    @(posedge CLK_I) disable iff (!NRST_I)
      (!in_low && mode_r == MODE_ALT && !cpu_force_r) |-> (SUBSYS_EN_O == alt_tpl_r);
  endproperty
  a_alt_tpl: assert property (p_alt_tpl) else $error("Alternate template not applied");

  property p_clk_run;
    @(posedge CLK_I) disable iff (!NRST_I) !is_hib |-> CLK_RUN_O;
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("Clocks stopped outside hibernate");

  property p_ext_reg;
    @(posedge CLK_I) disable iff (!NRST_I) !reg_ctl_r[0] |-> !REGS_O.dig_en && !REGS_O.dig_buzz;
  endproperty
  a_ext_reg: assert property (p_ext_reg) else $error("Digital regulator not disabled");

  property p_hib_regs;
    @(posedge CLK_I) disable iff (!NRST_I) is_hib |-> !REGS_O.dig_en && !REGS_O.ana_en && !REGS_O.sleep_en;
  endproperty
  a_hib_regs: assert property (p_hib_regs) else $error("Regulator left on in hibernate");

  property p_no_buzz;
    @(posedge CLK_I) disable iff (!NRST_I) !is_sleep |-> !REGS_O.dig_buzz && !REGS_O.ana_buzz;
  endproperty
  a_no_buzz: assert property (p_no_buzz) else $error("Regulators buzzed outside sleep");

  property p_low_refuse;
    @(posedge CLK_I) disable iff (!NRST_I) (st_r == ST_LOW && wr_mode) |=> $stable(target_r);
  endproperty
  a_low_refuse: assert property (p_low_refuse) else $error("Mode write taken in low mode");

  property p_low_mode;
    @(posedge CLK_I) disable iff (!NRST_I) (st_r == ST_LOW) |-> (MODE_O == MODE_SLEEP) || (MODE_O == MODE_HIB);
  endproperty
  a_low_mode: assert property (p_low_mode) else $error("Low state without low mode");

  property p_cpu_on;
    @(posedge CLK_I) disable iff (!NRST_I) (st_r == ST_RESUME && st_nxt == ST_RUN) |=> SUBSYS_EN_O[CPU_BIT];
  endproperty
  a_cpu_on: assert property (p_cpu_on) else $error("CPU not enabled after wakeup");

  property p_abort;
    @(posedge CLK_I) disable iff (!NRST_I) (st_r == ST_ENTER && low_tgt && wake_q) |=> (st_r == ST_RUN) && (MODE_O == MODE_ACTIVE);
  endproperty
  a_abort: assert property (p_abort) else $error("Wakeup did not abort entry");

  property p_low_by_write;
    @(posedge CLK_I) disable iff (!NRST_I) (st_r == ST_RUN && $past(st_r) == ST_RUN && !wr_mode) |=> st_r == ST_RUN;
  endproperty
  a_low_by_write: assert property (p_low_by_write) else $error("Low mode entered without write");

endmodule // power_mode_controller

// File: sim/wake_src.sv
`timescale 1ns/1ps
module wake_src #(
  parameter int HOLD = 8
) (
  // Clock
  input  wire logic                CLK_I,
  // One-cycle requests from the bench
  input  wire logic [5:0]          FIRE_I,
  // Level wake lines
  output pwr_mode_pkg::wake_t      WAKE_O
);
  import pwr_mode_pkg::*;

  logic [3:0] cnt_r [6] = '{default: 4'h0};
  logic [5:0] lvl;

  // Stretch each request into a level held HOLD cycles
  always_ff @(posedge CLK_I) begin
    for (int i = 0; i < 6; i++) begin
      if (FIRE_I[i]) cnt_r[i] <= 4'(HOLD);
      else if (cnt_r[i] != 4'h0) cnt_r[i] <= cnt_r[i] - 4'h1;
    end
  end

  // Lines drop back low once the hold runs out
  always_comb begin
    for (int i = 0; i < 6; i++) lvl[i] = (cnt_r[i] != 4'h0);
  end
  assign WAKE_O = wake_t'(lvl);
endmodule // wake_src

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pwr_mode_pkg::*;

  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd_q, rd;
  logic hreadyout, hresp, clk_run;
  logic [5:0] fire = 6'h00;
  logic [15:0] subsys;
  wake_t wake;
  reg_ctl_t regs;
  gmode_t mode;
  int mismatches = 0, n_checks = 0, n;

  // Clock and read-data capture
  always #25 clk = ~clk;
  always @(posedge clk) rd_q <= hrdata;

  power_mode_controller dut (.CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata),
    .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .WAKE_I(wake), .SUBSYS_EN_O(subsys), .CLK_RUN_O(clk_run),
    .REGS_O(regs), .MODE_O(mode));

  wake_src #(.HOLD(8)) src (.CLK_I(clk), .FIRE_I(fire), .WAKE_O(wake));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi, input string what);
    n_checks++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("BAD %0t %s count %0d", $time, what, v);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // One AHB-Lite single word transfer, held until hready
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int k;
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    k = 0;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    #1;
    rd = rd_q;
    if (k >= 50) begin mismatches++; end_of_test(); end
    chk({31'h0, hresp}, 32'h0, "resp");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0);
    chk(rd, exp, "read");
  endtask

  task automatic pulse(input logic [5:0] f);
    fire <= f;
    cyc(1);
    fire <= 6'h00;
  endtask

  // Cycles until the mode shows m, bounded
  task automatic wait_mode(input gmode_t m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin cyc(1); n++; end
    if (n >= lim) begin mismatches++; end_of_test(); end
  endtask

  initial begin
    cyc(3);
    nrst <= 1'b1;
    cyc(1);
    // Reset state and register reset values
    chk({30'h0, mode}, 32'h0, "mode");
    chk({16'h0, subsys}, 32'h0000ffff, "subsys");
    chk({26'h0, regs}, 32'h33, "regs");
    rchk(ACT_TPL_OFS, 32'h0000ffff);
    rchk(ALT_TPL_OFS, 32'h0000fffe);
    rchk(REG_CTL_OFS, 32'h3);
    rchk(WAKE_EN_OFS, 32'h3f);
    rchk(8'h18, 32'h0);
    rchk(STATUS_OFS, 32'h0);
    $display("test reset done");
    // Alternate active, then back to active with a new template
    wr(ALT_TPL_OFS, 32'h00f0);
    wr(ACT_TPL_OFS, 32'h1234);
    wr(MODE_OFS, 32'h1);
    wait_mode(MODE_ALT, 20);
    rchk(MODE_OFS, 32'h1);
    chk({16'h0, subsys}, 32'h00f0, "alt tpl");
    chk({31'h0, clk_run}, 32'h1, "clk alt");
    wr(MODE_OFS, 32'h0);
    wait_mode(MODE_ACTIVE, 20);
    chk({16'h0, subsys}, 32'h1234, "act tpl");
    $display("test alt done");
    // Regulator disable under external supply
    wr(REG_CTL_OFS, 32'h0);
    cyc(2);
    chk({30'h0, regs.dig_en, regs.ana_en}, 32'h0, "reg off");
    wr(REG_CTL_OFS, 32'h3);
    cyc(2);
    chk({30'h0, regs.dig_en, regs.ana_en}, 32'h3, "reg on");
    $display("test regulators done");
    // Sleep: masked source ignored, enabled source resumes
    wr(WAKE_EN_OFS, 32'h37);
    wr(MODE_OFS, 32'h2);
    wait_mode(MODE_SLEEP, 20);
    chk({16'h0, subsys}, 32'h0, "sleep subsys");
    chk({30'h0, regs.dig_buzz, regs.ana_buzz}, 32'h3, "buzz");
    pulse(6'h08);
    cyc(40);
    chk({30'h0, mode}, 32'h2, "masked rtc");
    wr(MODE_OFS, 32'h3);
    chk({30'h0, mode}, 32'h2, "refused");
    rchk(STATUS_OFS, 32'h0a);
    pulse(6'h04);
    wait_mode(MODE_ACTIVE, 400);
    chk_rng(n, 290, 300, "sleep resume");
    chk({16'h0, subsys}, 32'h1235, "cpu on");
    $display("test sleep done");
    // Wake during entry aborts the entry
    wr(MODE_OFS, 32'h2);
    pulse(6'h01);
    cyc(12);
    chk({30'h0, mode}, 32'h0, "abort");
    $display("test abort done");
    // Hibernate: only port interrupt wakes, state kept
    wr(WAKE_EN_OFS, 32'h3f);
    wr(MODE_OFS, 32'h3);
    wait_mode(MODE_HIB, 20);
    chk({31'h0, clk_run}, 32'h0, "clk hib");
    chk({26'h0, regs}, 32'h01, "hib regs");
    chk({16'h0, subsys}, 32'h0, "hib subsys");
    pulse(6'h3d);
    cyc(40);
    chk({30'h0, mode}, 32'h3, "hib ignore");
    pulse(6'h02);
    wait_mode(MODE_ACTIVE, 2100);
    chk_rng(n, 1990, 1999, "hib resume");
    chk({16'h0, subsys}, 32'h1235, "hib cpu on");
    rchk(ACT_TPL_OFS, 32'h1234);
    $display("test hibernate done");
    end_of_test();
  end
endmodule // tb_top
